//--- core/vdc_cycle_ctrl.v
`include "vdc_defs.vh"
`default_nettype none
module vdc_cycle_ctrl (
  input  wire        sys_clk,
  input  wire        srst,
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  output reg         row_strobe_n,
  output reg         col_strobe_n,
  output reg         transfer_output_enable_n,
  output reg         upper_byte_write_enable_n,
  output reg         lower_byte_write_enable_n,
  output reg         special_function_select,
  output reg  [8:0]  addr,
  output reg  [15:0] io_out,
  output reg         io_oe,
  input  wire [15:0] io_in
);
  localparam S_IDLE = 3'd0;
  localparam S_ROW  = 3'd1;
  localparam S_COL  = 3'd2;
  localparam S_HOLD = 3'd3;
  localparam S_END  = 3'd4;

  reg [2:0]  st_q;
  reg [3:0]  cmd_q;
  reg [17:0] addr_q;
  reg [15:0] data_q;
  reg [15:0] rdata_q;
  reg        newmask_q;
  reg        refen_q;
  reg        err_q;
  reg        last_rd_q;
  reg [19:0] refcnt_q;
  reg        refdue_q;
  reg [15:0] io_s1_q;
  reg [15:0] io_s2_q;
  wire       tick;
  wire       busy = (st_q != S_IDLE);

  // true for the four counter-refresh commands, hidden refresh included
  function is_cbr;
    input [3:0] c;
    begin
      is_cbr = (c == `VDC_CMD_CBR_OPT) || (c == `VDC_CMD_CBR_STOP) ||
               (c == `VDC_CMD_CBR_NONE) || (c == `VDC_CMD_HIDDEN);
    end
  endfunction

  vdc_phase_div #(.DIV(`VDC_PHASE_CYC)) u_div (
    .sys_clk (sys_clk),
    .srst    (srst),
    .clr     (!busy),
    .tick    (tick)
  );

  // ==========================================================
  // data pins come from outside: two flops before use
  always @(posedge sys_clk) begin
    io_s1_q <= io_in;
    io_s2_q <= io_s1_q;
  end

  // ==========================================================
  // refresh interval: one due flag every 8 ms / 512
  always @(posedge sys_clk) begin
    if (srst) begin
      refcnt_q <= 20'h00000;
      refdue_q <= 1'b0;
    end else begin
      if (refcnt_q == `VDC_REF_INT_CYC - 1) begin
        refcnt_q <= 20'h00000;
        refdue_q <= 1'b1;
      end else begin
        refcnt_q <= refcnt_q + 20'h00001;
        if (st_q == S_END && is_cbr(cmd_q))
          refdue_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // register port, read data one cycle later
  always @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `VDC_REG_CMD:    reg_rdata <= {12'h000, cmd_q};
        `VDC_REG_ADDR:   reg_rdata <= addr_q[15:0];
        `VDC_REG_DATA:   reg_rdata <= data_q;
        `VDC_REG_STATUS: reg_rdata <= {12'h000, err_q, refdue_q,
                                       newmask_q, busy};
        `VDC_REG_RDATA:  reg_rdata <= rdata_q;
        `VDC_REG_REFCTL: reg_rdata <= {15'h0000, refen_q};
        default:         reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ==========================================================
  // cycle sequencer: row edge, column edge, release
  always @(posedge sys_clk) begin
    if (srst) begin
      st_q <= S_IDLE;
      cmd_q <= 4'h0;
      addr_q <= 18'h00000;
      data_q <= 16'h0000;
      rdata_q <= 16'h0000;
      newmask_q <= 1'b0;
      refen_q <= `VDC_REFCTL_RST;
      err_q <= 1'b0;
      last_rd_q <= 1'b0;
      row_strobe_n <= 1'b1;
      col_strobe_n <= 1'b1;
      transfer_output_enable_n <= 1'b1;
      upper_byte_write_enable_n <= 1'b1;
      lower_byte_write_enable_n <= 1'b1;
      special_function_select <= 1'b0;
      addr <= 9'h000;
      io_out <= 16'h0000;
      io_oe <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `VDC_REG_ADDR)
        addr_q <= {2'b00, reg_wdata};
      if (reg_wr && reg_addr == `VDC_REG_DATA)
        data_q <= reg_wdata;
      if (reg_wr && reg_addr == `VDC_REG_REFCTL)
        refen_q <= reg_wdata[0];
      case (st_q)
        S_IDLE: begin
          if (reg_wr && reg_addr == `VDC_REG_CMD) begin
            cmd_q <= reg_wdata[3:0];
            err_q <= busy;
            // hidden refresh only right after a read
            if (reg_wdata[3:0] == `VDC_CMD_HIDDEN && !last_rd_q)
              err_q <= 1'b1;
            else
              st_q <= S_ROW;
          end else if (refen_q && refdue_q) begin
            cmd_q <= `VDC_CMD_CBR_NONE;
            st_q <= S_ROW;
          end
        end
        S_ROW: if (tick) begin
          // levels set up before the row strobe falls
          special_function_select <= 1'b0;
          upper_byte_write_enable_n <= 1'b1;
          lower_byte_write_enable_n <= 1'b1;
          transfer_output_enable_n <= 1'b1;
          col_strobe_n <= 1'b1;
          addr <= addr_q[17:9]; // row from address register bits 17:9
          io_oe <= 1'b0;
          case (cmd_q)
            `VDC_CMD_MWRITE, `VDC_CMD_BLOCK: begin
              upper_byte_write_enable_n <= 1'b0;
              lower_byte_write_enable_n <= 1'b0;
              io_out <= data_q; // select stays low at the row edge
              io_oe <= newmask_q; // mask only for new method
            end
            `VDC_CMD_SETCOLOR, `VDC_CMD_SETMASK: begin
              transfer_output_enable_n <= 1'b1;
              special_function_select <= 1'b1;
            end
            `VDC_CMD_CBR_OPT: begin
              col_strobe_n <= 1'b0;
            end
            `VDC_CMD_CBR_STOP: begin
              col_strobe_n <= 1'b0;
              special_function_select <= 1'b1;
              upper_byte_write_enable_n <= 1'b0;
              lower_byte_write_enable_n <= 1'b0;
              addr <= addr_q[8:0];
            end
            `VDC_CMD_CBR_NONE: begin
              col_strobe_n <= 1'b0;
              special_function_select <= 1'b1;
            end
            `VDC_CMD_HIDDEN: begin
              col_strobe_n <= 1'b0; // keep strobes low
              transfer_output_enable_n <= 1'b0;
              special_function_select <= 1'b1;
            end
            default: ;
          endcase
          st_q <= S_COL;
        end
        S_COL: if (tick) begin
          // row falls alone; a column edge here would read as refresh
          row_strobe_n <= 1'b0; // one edge per cycle
          st_q <= S_HOLD;
        end
        S_HOLD: if (tick) begin
          addr <= addr_q[8:0];
          io_oe <= 1'b0;
          case (cmd_q)
            `VDC_CMD_READ: begin
              col_strobe_n <= 1'b0;
              transfer_output_enable_n <= 1'b0;
            end
            `VDC_CMD_WRITE, `VDC_CMD_MWRITE: begin
              col_strobe_n <= 1'b0;
              upper_byte_write_enable_n <= 1'b0;
              lower_byte_write_enable_n <= 1'b0;
              special_function_select <= 1'b0;
              io_out <= data_q;
              io_oe <= 1'b1; // per-bit mask applied by device for MWRITE (and BLOCK), not for WRITE
            end
            `VDC_CMD_BLOCK: begin
              col_strobe_n <= 1'b0;
              upper_byte_write_enable_n <= 1'b0;
              lower_byte_write_enable_n <= 1'b0;
              special_function_select <= 1'b1;
              io_out <= data_q; // column select per IO bit
              io_oe <= 1'b1;
            end
            `VDC_CMD_SETCOLOR, `VDC_CMD_SETMASK: begin
              col_strobe_n <= 1'b0;
              special_function_select <= (cmd_q == `VDC_CMD_SETCOLOR);
              upper_byte_write_enable_n <= 1'b0;
              lower_byte_write_enable_n <= 1'b0;
              io_out <= data_q;
              io_oe <= 1'b1;
            end
            `VDC_CMD_CBR_OPT, `VDC_CMD_CBR_STOP,
            `VDC_CMD_CBR_NONE, `VDC_CMD_HIDDEN: io_oe <= 1'b0;
            default: ;
          endcase
          st_q <= S_END;
        end
        S_END: if (tick) begin
          if (cmd_q == `VDC_CMD_READ)
            rdata_q <= io_s2_q;
          // a mask register write selects the stored mask; VDC_CMD_CBR_OPT selects the row-edge mask
          if (cmd_q == `VDC_CMD_SETMASK)
            newmask_q <= 1'b0;
          if (cmd_q == `VDC_CMD_CBR_OPT)
            newmask_q <= 1'b1;
          row_strobe_n <= 1'b1;
          upper_byte_write_enable_n <= 1'b1;
          lower_byte_write_enable_n <= 1'b1;
          io_oe <= 1'b0;
          // a read leaves both low so a hidden refresh can follow
          if (cmd_q != `VDC_CMD_READ) begin
            col_strobe_n <= 1'b1;
            transfer_output_enable_n <= 1'b1;
          end
          last_rd_q <= (cmd_q == `VDC_CMD_READ);
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule // vdc_cycle_ctrl
`default_nettype wire

//--- common/vdc_defs.vh
`ifndef VDC_DEFS_VH
`define VDC_DEFS_VH
// ==========================================================
// register offsets of the controller's own command port
`define VDC_REG_CMD      4'h0
`define VDC_REG_ADDR     4'h1
`define VDC_REG_DATA     4'h2
`define VDC_REG_STATUS   4'h3
`define VDC_REG_RDATA    4'h4
`define VDC_REG_REFCTL   4'h5
// ==========================================================
// command codes written to the command register
`define VDC_CMD_READ     4'h1
`define VDC_CMD_WRITE    4'h2
`define VDC_CMD_MWRITE   4'h3
`define VDC_CMD_BLOCK    4'h4
`define VDC_CMD_SETCOLOR 4'h5
`define VDC_CMD_SETMASK  4'h6
`define VDC_CMD_CBR_OPT  4'h7
`define VDC_CMD_CBR_STOP 4'h8
`define VDC_CMD_CBR_NONE 4'h9
`define VDC_CMD_ROR      4'hA
`define VDC_CMD_HIDDEN   4'hB
// ==========================================================
// field positions and reset values
`define VDC_ST_BUSY      0
`define VDC_ST_NEWMASK   1
`define VDC_ST_REFDUE    2
`define VDC_ST_ERR       3
`define VDC_REFCTL_RST   1'b1
// ==========================================================
// timing: 512 refreshes per 8 ms, 50 MHz clock
`define VDC_CLK_HZ       50000000
`define VDC_REF_ROWS     512
`define VDC_REF_PERIOD_US 8000
`define VDC_REF_INT_CYC  ((`VDC_REF_PERIOD_US * (`VDC_CLK_HZ / 1000000)) / `VDC_REF_ROWS)
`define VDC_PHASE_CYC    3
`endif

//--- core/vdc_phase_div.v
`default_nettype none
// ==========================================================
// one-cycle enable pulse every DIV clocks
module vdc_phase_div #(
  parameter DIV = 3
) (
  input  wire       sys_clk,
  input  wire       srst,
  input  wire       clr,
  output reg        tick
);
  reg [7:0] cnt_q;
  // ==========================================================
  // counter restarts on clr so a cycle phase begins aligned
  always @(posedge sys_clk) begin
    if (srst || clr) begin
      cnt_q <= 8'h00;
      tick  <= 1'b0;
    end else if (cnt_q == DIV[7:0] - 8'h01) begin
      cnt_q <= 8'h00;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      tick  <= 1'b0;
    end
  end
endmodule // vdc_phase_div
`default_nettype wire

//--- testbench/vdc_dev_model.sv
`include "vdc_defs.vh"
`default_nettype none
// ==========================================================
// behavioural video dram port, sampled on the bench clock
module vdc_dev_model (
  input  wire logic        sys_clk,
  input  wire logic        row_strobe_n,
  input  wire logic        col_strobe_n,
  input  wire logic        transfer_output_enable_n,
  input  wire logic        upper_byte_write_enable_n,
  input  wire logic        lower_byte_write_enable_n,
  input  wire logic        special_function_select,
  input  wire logic [8:0]  addr,
  input  wire logic [15:0] io_out,
  input  wire logic        io_oe,
  output var  logic [15:0] io_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:7];
  logic [15:0] color_q, wmask_q = 16'hFFFF, msk_q, wd_q;
  logic [8:0]  refcnt_q = 9'h000, split_q;
  logic [2:0]  col_q;
  logic        rp = 1'b1, cp = 1'b1, newm_q = 1'b0, wp_q = 1'b0;
  logic        rset_q = 1'b0, ref_q, mw_q, bw_q, ub_q, lb_q;
  wire  logic  u = upper_byte_write_enable_n;
  wire  logic  l = lower_byte_write_enable_n;
  initial begin
    for (int i = 0; i < 8; i++)
      mem[i] = 16'h0000;
    io_in = 16'h0000;
  end
  // written bits: byte lane, column select and mask together
  function automatic logic [15:0] put(input logic [15:0] o, n,
                                      input logic hi, lo);
    logic [15:0] m;
    m = {{8{hi & ub_q}}, {8{lo & lb_q}}} & (mw_q ? msk_q : 16'hFFFF);
    return (o & ~m) | (n & m);
  endfunction
  // decode at row fall, act at column fall, commit at row rise
  always @(posedge sys_clk) begin
    rp <= row_strobe_n;
    cp <= col_strobe_n;
    if (rp && !row_strobe_n) begin
      rset_q <= col_strobe_n && transfer_output_enable_n && u && l
                && special_function_select;
      ref_q <= !col_strobe_n;
      mw_q <= !u && !l;
      msk_q <= newm_q ? io_out : wmask_q;
      if (!col_strobe_n) begin
        refcnt_q <= refcnt_q + 9'h001;
        if (!special_function_select) begin
          split_q <= 9'h1FF;
          newm_q <= 1'b1;
        end else if (!u && !l)
          split_q <= addr; // all-high keeps state
      end
    end
    if (cp && !col_strobe_n && !row_strobe_n) begin
      col_q <= addr[2:0];
      if (rset_q && special_function_select)
        color_q <= io_out;
      else if (rset_q) begin
        wmask_q <= io_out;
        newm_q <= 1'b0;
      end
    end
    if (!rp && !row_strobe_n && !col_strobe_n && !(u && l) && !rset_q
        && !ref_q) begin
      wp_q <= 1'b1;
      wd_q <= io_out;
      bw_q <= special_function_select;
      ub_q <= !u;
      lb_q <= !l;
    end
    if (!rp && row_strobe_n && wp_q) begin
      wp_q <= 1'b0;
      for (int i = 0; i < 8; i++)
        if (bw_q)
          mem[i] <= put(mem[i], color_q, wd_q[8+i], wd_q[i]);
      if (!bw_q)
        mem[col_q] <= put(mem[col_q], wd_q, 1'b1, 1'b1);
    end
  end
  // pins answer half a clock after the strobes, like an access time;
  // hidden refresh keeps the read word on the pins
  always @(negedge sys_clk) begin
    if (!col_strobe_n && !transfer_output_enable_n)
      io_in <= mem[(cp && !row_strobe_n) ? addr[2:0] : col_q];
    else
      io_in <= ~io_in; // released, no pull
  end
endmodule // vdc_dev_model
`default_nettype wire

//--- testbench/vdc_chk_sva.sv
`include "vdc_defs.vh"
`default_nettype none
// ==========================================================
// pin sequencing checks on the cycle controller
module vdc_chk (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        row_strobe_n,
  input wire logic        col_strobe_n,
  input wire logic        transfer_output_enable_n,
  input wire logic        upper_byte_write_enable_n,
  input wire logic        lower_byte_write_enable_n,
  input wire logic        special_function_select,
  input wire logic        io_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        row_q, en_q;
  logic [11:0] gap_q;
  wire  logic  fall = row_q && !row_strobe_n;
  wire  logic  col = col_strobe_n;
  wire  logic  toe = transfer_output_enable_n;
  wire  logic  u = upper_byte_write_enable_n;
  wire  logic  l = lower_byte_write_enable_n;
  wire  logic  sfs = special_function_select;
  // gap since last row strobe, owed only while auto refresh is on
  always_ff @(posedge sys_clk) begin
    row_q <= row_strobe_n;
    if (srst)
      en_q <= `VDC_REFCTL_RST;
    else if (reg_wr && reg_addr == `VDC_REG_REFCTL)
      en_q <= reg_wdata[0];
    gap_q <= (srst || fall || !en_q) ? 12'h000 : gap_q + 12'h001;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  reg_set_a: assert property (
    fall && col && toe && u && l && sfs |-> ##[1:6] !col)
    else $error("register set without column strobe");
  cbr_order_a: assert property (
    fall && !col |-> !$past(col_strobe_n))
    else $error("column strobe not ahead of row strobe");
  cbr_quiet_a: assert property (
    fall && !col && toe |-> !io_oe [*3])
    else $error("data driven during counter refresh");
  hidden_a: assert property (
    fall && !col && !toe |-> !io_oe)
    else $error("data driven during hidden refresh");
  mask_wr_a: assert property (
    fall && col && !u && !l |-> toe && !sfs)
    else $error("mask write with wrong select levels");
  col_data_a: assert property (
    $fell(col_strobe_n) && !row_strobe_n && toe && !(u && l) |-> io_oe)
    else $error("write column strobe without data");
  row_hold_a: assert property (
    fall |-> !row_strobe_n [*3])
    else $error("row strobe low too briefly");
  ref_gap_a: assert property (
    gap_q < 12'h352)
    else $error("refresh interval overrun");
endmodule // vdc_chk
bind vdc_cycle_ctrl vdc_chk u_chk (
  .sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .row_strobe_n,
  .col_strobe_n, .transfer_output_enable_n, .upper_byte_write_enable_n,
  .lower_byte_write_enable_n, .special_function_select, .io_oe
);
`default_nettype wire

//--- testbench/tb_top.sv
`include "vdc_defs.vh"
`default_nettype none
// ==========================================================
// register level regression of the cycle controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        row_q = 1'b1;
  wire  logic [15:0] reg_rdata, io_out, io_in;
  wire  logic [8:0]  addr;
  wire  logic  row_strobe_n, col_strobe_n, io_oe, special_function_select;
  wire  logic  transfer_output_enable_n, upper_byte_write_enable_n;
  wire  logic  lower_byte_write_enable_n;
  int          err_total = 0, tests_run = 0, cyc = 0, falls = 0, f0;
  always #10 sys_clk = ~sys_clk;
  vdc_cycle_ctrl dut (
    .sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .row_strobe_n, .col_strobe_n, .transfer_output_enable_n,
    .upper_byte_write_enable_n, .lower_byte_write_enable_n,
    .special_function_select, .addr, .io_out, .io_oe, .io_in);
  vdc_dev_model u_dev (
    .sys_clk, .row_strobe_n, .col_strobe_n, .transfer_output_enable_n,
    .upper_byte_write_enable_n, .lower_byte_write_enable_n,
    .special_function_select, .addr, .io_out, .io_oe, .io_in);
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // hang guard; whole run is a few thousand cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    row_q <= row_strobe_n;
    if (row_q && !row_strobe_n)
      falls <= falls + 1;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
  task automatic rc(input logic [3:0] a, input logic [15:0] m, e);
    logic [15:0] d;
    rd(a, d);
    chk(d & m, e);
  endtask
  // one command, then poll busy with a bound
  task automatic op(input logic [3:0] c, input logic [15:0] a, d);
    logic [15:0] s;
    wr(`VDC_REG_ADDR, a);
    wr(`VDC_REG_DATA, d);
    wr(`VDC_REG_CMD, {12'h000, c});
    s = 16'h0001;
    for (int n = 0; n < 100 && s[`VDC_ST_BUSY] !== 1'b0; n++)
      rd(`VDC_REG_STATUS, s);
    chk({15'h0000, s[`VDC_ST_BUSY]}, 16'h0000);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    rc(`VDC_REG_REFCTL, 16'h0001, {15'h0000, `VDC_REFCTL_RST});
    wr(`VDC_REG_REFCTL, 16'h0000);
    rc(4'hF, 16'hFFFF, 16'h0000);
    op(`VDC_CMD_HIDDEN, 16'h0000, 16'h0000);
    rc(`VDC_REG_STATUS, 16'h0008, 16'h0008);
    op(`VDC_CMD_WRITE, 16'h0001, 16'h1234);
    op(`VDC_CMD_READ, 16'h0001, 16'h0000);
    rc(`VDC_REG_RDATA, 16'hFFFF, 16'h1234);
    op(`VDC_CMD_SETMASK, 16'h0000, 16'h00FF);
    rc(`VDC_REG_STATUS, 16'h0002, 16'h0000);
    op(`VDC_CMD_MWRITE, 16'h0001, 16'hABCD);
    op(`VDC_CMD_READ, 16'h0001, 16'h0000);
    rc(`VDC_REG_RDATA, 16'hFFFF, 16'h12CD);
    op(`VDC_CMD_SETCOLOR, 16'h0000, 16'h5A5A);
    op(`VDC_CMD_BLOCK, 16'h0000, 16'h0006);
    op(`VDC_CMD_READ, 16'h0002, 16'h0000);
    rc(`VDC_REG_RDATA, 16'hFFFF, 16'h005A);
    op(`VDC_CMD_CBR_OPT, 16'h0000, 16'h0000);
    rc(`VDC_REG_STATUS, 16'h0002, 16'h0002);
    op(`VDC_CMD_CBR_STOP, 16'h0155, 16'h0000);
    op(`VDC_CMD_CBR_NONE, 16'h0000, 16'h0000);
    rc(`VDC_REG_STATUS, 16'h0002, 16'h0002);
    op(`VDC_CMD_MWRITE, 16'h0003, 16'hF00F);
    op(`VDC_CMD_READ, 16'h0003, 16'h0000);
    rc(`VDC_REG_RDATA, 16'hFFFF, 16'hF00F);
    op(`VDC_CMD_ROR, 16'h0001, 16'h0000);
    op(`VDC_CMD_READ, 16'h0001, 16'h0000);
    rc(`VDC_REG_RDATA, 16'hFFFF, 16'h125A);
    op(`VDC_CMD_HIDDEN, 16'h0000, 16'h0000);
    wr(`VDC_REG_REFCTL, 16'h0001);
    f0 = falls;
    repeat (1700) @(posedge sys_clk);
    chk({15'h0000, (falls - f0) >= 2}, 16'h0001);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
